// File: include/adcdc_map.svh
// Constant map for the chained converter readout link.
// Assumes inclusion by bare name; holds definitions only.
`ifndef ADCDC_MAP_SVH
`define ADCDC_MAP_SVH

// Result width of one converter in the chain.
`define ADCDC_RES_W        16
// Index of the most significant result bit.
`define ADCDC_MSB          15
// System clock period in nanoseconds.
`define ADCDC_SYS_NS       20
// Least low time of the conversion-start pulse, in nanoseconds.
`define ADCDC_CS_LOW_NS    1000
// Least time the mode level on SCLK stands after the start edge, in nanoseconds.
`define ADCDC_HOLD_NS      500
// Fixed wait for conversion when no busy indication is used, in nanoseconds.
`define ADCDC_CONV_WAIT_NS 4000
// Cycle counts derived from the times above, least times rounded up.
`define ADCDC_CS_LOW_CYC   ((`ADCDC_CS_LOW_NS + `ADCDC_SYS_NS - 1) / `ADCDC_SYS_NS)
`define ADCDC_HOLD_CYC     ((`ADCDC_HOLD_NS + `ADCDC_SYS_NS - 1) / `ADCDC_SYS_NS)
`define ADCDC_CONV_CYC     ((`ADCDC_CONV_WAIT_NS + `ADCDC_SYS_NS - 1) / `ADCDC_SYS_NS)
// Width of the host timing counter.
`define ADCDC_TMR_W        16
// Reset level of the converter pin synchronisers: start high, others low.
// Matching the idle start line keeps a false start rise out after reset.
`define ADCDC_PIN_IDLE     3'h1
// Level of the shared data line when nobody drives it (pull-up).
`define ADCDC_PULL_LVL     1'h1

`endif

// File: include/adcdc_pkg.sv
// Types shared by both ends of the chained converter link.
// Assumes nothing of its surroundings.
package adcdc_pkg;

   // Converter end: idle, converting, acquiring with result ready.
   typedef enum logic [1:0] {
      DS_IDLE = 2'h0,
      DS_CONV = 2'h1,
      DS_ACQ  = 2'h2
   } adcdc_dev_state_t;

   // Host end: idle, start low, start high with mode hold, wait, clock high, clock low.
   typedef enum logic [2:0] {
      HS_IDLE = 3'h0,
      HS_LOW  = 3'h1,
      HS_RISE = 3'h2,
      HS_WAIT = 3'h3,
      HS_HI   = 3'h4,
      HS_LO   = 3'h5
   } adcdc_host_state_t;

endpackage

// File: include/adcdc_link_if.sv
// Link between one converter and its neighbours or the host.
// Assumes the bench drives sdi from the upstream party; sdo has a pull-up.
`timescale 1ns/1ps
`include "adcdc_map.svh"

interface adcdc_link_if;
   logic conv_start; // Conversion-start line, driven by the host.
   logic sclk;       // Serial clock, driven by the host.
   logic sdi;        // Converter data input, from upstream or the board.
   logic sdo_o;      // Converter data output value.
   logic sdo_oe;     // Converter data output enable, high while driving.
   logic sdo_line;   // Resolved level on the data output wire.

   // The pull-up holds the wire high when the converter lets go.
   assign sdo_line = sdo_oe ? sdo_o : `ADCDC_PULL_LVL;

   modport dev  (input conv_start, input sclk, input sdi, output sdo_o, output sdo_oe);
   modport host (output conv_start, output sclk, input sdo_line);
endinterface // adcdc_link_if

// File: core/adcdc_dev.sv
// Converter end of the chained readout link with busy indication.
// Assumes link_clk is the link's own free clock, much faster than sclk,
// and that sample_data is stable while a conversion finishes.
//
// How it works
// - SDI low at start rise selects chain mode
// - Board may tie SDI to conversion start
// - Start pulses low then high; rise converts
// - SCLK high at start rise selects busy
// - Chain mode drives SDO at all times
// - SDI and start both low drive SDO low
// - Conversion done returns to acquisition, busy shown
// - Busy out needs own done and upstream enable
// - Shift result on SCLK fall, SDI shifts in
// - Busy mode: first fall does not shift
// - Own result goes out MSB first
`timescale 1ns/1ps
`include "adcdc_map.svh"

module adcdc_dev #(
   parameter int CONV_CYC = 40 // Conversion length in link clock cycles.
) (
   input  wire logic                    link_clk,    // Link clock, free running.
   input  wire logic                    rst_n,       // Asynchronous reset, active low.
   adcdc_link_if.dev                    lnk,         // Pins toward host and chain.
   input  wire logic [`ADCDC_RES_W-1:0] sample_data, // Result from the analog core.
   output logic                         chain_mode,  // Chain mode selected.
   output logic                         busy_mode,   // Busy indication selected.
   output logic                         converting,  // Conversion in progress.
   output logic                         result_rdy   // Result held for readout.
);

   // The conversion counter needs at least two cycles to load a result.
   if (CONV_CYC < 2) begin : g_chk
      $error("CONV_CYC must be at least 2");
   end

   localparam int CNT_W = $clog2(CONV_CYC + 1);

   // Pin synchronisers: bit 0 start, bit 1 sclk, bit 2 sdi.
   logic [2:0]                  pin_m_r;   // First stage, read only by the second.
   logic [2:0]                  pin_s_r;   // Second stage, safe to use.
   logic [2:0]                  pin_d_r;   // Previous second-stage value for edges.
   logic                        cs_s;      // Synchronised start line.
   logic                        sclk_s;    // Synchronised serial clock.
   logic                        sdi_s;     // Synchronised upstream data.
   logic                        cs_rise;   // Start line rose.
   logic                        sclk_fall; // Serial clock fell.

   // Control and data state.
   adcdc_pkg::adcdc_dev_state_t state_r, state_nxt;       // Phase of the converter.
   logic [CNT_W-1:0]            cnt_r, cnt_nxt;           // Conversion timer.
   logic                        chain_r, chain_nxt;       // Chain mode latched at start.
   logic                        busy_r, busy_nxt;         // Busy mode latched at start.
   logic                        first_r, first_nxt;       // First fall still to come.
   logic                        done_r, done_nxt;         // Result loaded.
   logic [`ADCDC_RES_W-1:0]     shreg_r, shreg_nxt;       // Output shift register.
   logic                        sdo_r, sdo_nxt;           // Output pin value.
   logic                        oe_r, oe_nxt;             // Output pin enable.
   logic                        conv_r, conv_nxt;         // Converting flag for user side.

   // Every pin passes two flip-flops before any logic looks at it.
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_m_r <= `ADCDC_PIN_IDLE;
         pin_s_r <= `ADCDC_PIN_IDLE;
         pin_d_r <= `ADCDC_PIN_IDLE;
      end else begin
         pin_m_r <= {lnk.sdi, lnk.sclk, lnk.conv_start};
         pin_s_r <= pin_m_r;
         pin_d_r <= pin_s_r;
      end
   end

   // Edge detection works only on the second stage and its delayed copy.
   always_comb begin
      cs_s      = pin_s_r[0];
      sclk_s    = pin_s_r[1];
      sdi_s     = pin_s_r[2];
      cs_rise   = pin_s_r[0] & ~pin_d_r[0];
      sclk_fall = ~pin_s_r[1] & pin_d_r[1];
   end

   // Next state of the mode, conversion and shift logic.
   // A new start edge wins over everything, as on the real part a rise
   // always ends acquisition; a pending readout is simply abandoned.
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      chain_nxt = chain_r;
      busy_nxt  = busy_r;
      first_nxt = first_r;
      done_nxt  = done_r;
      shreg_nxt = shreg_r;
      conv_nxt  = conv_r;
      if (cs_rise) begin
         // Mode straps are sampled at the start rise.
         // A data input tied to the start line rises with it, so the level
         // one cycle before the rise is the strap.
         chain_nxt = ~pin_d_r[2];
         busy_nxt  = sclk_s;
         first_nxt = sclk_s;
         state_nxt = adcdc_pkg::DS_CONV;
         cnt_nxt   = '0;
         done_nxt  = 1'h0;
         conv_nxt  = 1'h1;
      end else begin
         case (state_r)
            adcdc_pkg::DS_CONV: begin
               // Count out the conversion, then load the result.
               if (cnt_r == CNT_W'(CONV_CYC - 1)) begin
                  shreg_nxt = sample_data;
                  done_nxt  = 1'h1;
                  conv_nxt  = 1'h0;
                  state_nxt = adcdc_pkg::DS_ACQ;
               end else begin
                  cnt_nxt = cnt_r + CNT_W'(1);
               end
            end
            adcdc_pkg::DS_ACQ: begin
               // Readout: each falling edge moves one bit along the chain, except the first one in busy mode.
               if (sclk_fall) begin
                  if (first_r) begin
                     // The busy bit is dropped, nothing shifts.
                     first_nxt = 1'h0;
                  end else begin
                     // Own MSB leaves first, upstream data follows.
                     shreg_nxt = {shreg_r[`ADCDC_MSB-1:0], sdi_s};
                  end
               end
            end
            default: begin
               // Idle waits for the first start rise.
               state_nxt = adcdc_pkg::DS_IDLE;
            end
         endcase
      end
   end

   // Next value of the output pin.
   // The pin is computed from next-state values so it changes in the
   // same cycle as the shift register, not one cycle later.
   always_comb begin
      oe_nxt  = chain_nxt;
      sdo_nxt = `ADCDC_PULL_LVL;
      if (!sdi_s && !cs_s) begin
         // Pass the low level on in every mode, or a part released by a
         // non-chain frame would never let the next part select chain mode.
         oe_nxt  = 1'h1;
         sdo_nxt = 1'h0;
      end else if (chain_nxt) begin
         if (done_nxt && busy_nxt && first_nxt) begin
            // Busy only when own result is ready and upstream enables it.
            sdo_nxt = sdi_s;
         end else if (done_nxt) begin
            // Result bits, most significant first.
            sdo_nxt = shreg_nxt[`ADCDC_MSB];
         end else begin
            // While converting the busy line stays low.
            sdo_nxt = 1'h0;
         end
      end
   end

   // Register all state; a fall during a conversion, as when the host parks
   // its busy strap low, is ignored, since only acquisition shifts.
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= adcdc_pkg::DS_IDLE;
         cnt_r   <= '0;
         chain_r <= 1'h0;
         busy_r  <= 1'h0;
         first_r <= 1'h0;
         done_r  <= 1'h0;
         shreg_r <= '0;
         sdo_r   <= 1'h1;
         oe_r    <= 1'h0;
         conv_r  <= 1'h0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         chain_r <= chain_nxt;
         busy_r  <= busy_nxt;
         first_r <= first_nxt;
         done_r  <= done_nxt;
         shreg_r <= shreg_nxt;
         sdo_r   <= sdo_nxt;
         oe_r    <= oe_nxt;
         conv_r  <= conv_nxt;
      end
   end

   // Pins and user flags come straight from flip-flops.
   assign lnk.sdo_o  = sdo_r;
   assign lnk.sdo_oe = oe_r;
   assign chain_mode = chain_r;
   assign busy_mode  = busy_r;
   assign converting = conv_r;
   assign result_rdy = done_r;

endmodule // adcdc_dev

// File: core/adcdc_host.sv
// Host end of the chained readout link.
// Assumes sys_clk at 50 MHz; sclk is divided from it and driven out.
// The data line from the last converter is a pin and is synchronised.
`timescale 1ns/1ps
`include "adcdc_map.svh"

module adcdc_host #(
   parameter int N_DEV     = 3, // Converters in the chain.
   parameter int SCLK_HALF = 16 // System cycles per sclk half period.
) (
   input  wire logic                    sys_clk,    // System clock.
   input  wire logic                    rst_n,      // Asynchronous reset, active low.
   adcdc_link_if.host                   lnk,        // Pins toward the chain.
   input  wire logic                    start,      // One-cycle request for a frame.
   input  wire logic                    busy_sel,   // Use busy indication this frame.
   output logic                         ready,      // Idle, a request is taken.
   output logic                         word_valid, // One-cycle pulse per word.
   output logic [`ADCDC_RES_W-1:0]      word_data   // Word, last converter first.
);

   // The converter sees sclk through a 64 ns synchroniser; slower halves are safe.
   if (SCLK_HALF < 16 || N_DEV < 1) begin : g_chk
      $error("SCLK_HALF must be at least 16 and N_DEV at least 1");
   end

   localparam int TOT = `ADCDC_RES_W * N_DEV + 1;
   localparam int EW  = $clog2(TOT + 1);

   adcdc_pkg::adcdc_host_state_t state_r, state_nxt; // Frame phase.
   logic [`ADCDC_TMR_W-1:0]      tmr_r, tmr_nxt;     // Phase timer.
   logic [EW-1:0]                edge_r, edge_nxt;   // Falling edges made.
   logic [3:0]                   bit_r, bit_nxt;     // Bits in the current word.
   logic                         cs_r, cs_nxt;       // Start line.
   logic                         sclk_r, sclk_nxt;   // Serial clock.
   logic                         bsel_r, bsel_nxt;   // Busy mode of this frame.
   logic                         rdy_r, rdy_nxt;     // Ready flag.
   logic                         wv_r, wv_nxt;       // Word valid pulse.
   logic [`ADCDC_RES_W-1:0]      sh_r, sh_nxt;       // Capture register.
   logic [`ADCDC_RES_W-1:0]      wd_r, wd_nxt;       // Word output.
   logic                         sdo_m_r;            // First synchroniser stage.
   logic                         sdo_s_r;            // Second synchroniser stage.

   // Next-state logic of the frame sequencer.
   always_comb begin
      state_nxt = state_r;
      tmr_nxt   = tmr_r + `ADCDC_TMR_W'(1);
      edge_nxt  = edge_r;
      bit_nxt   = bit_r;
      cs_nxt    = cs_r;
      sclk_nxt  = sclk_r;
      bsel_nxt  = bsel_r;
      rdy_nxt   = 1'h0;
      wv_nxt    = 1'h0;
      sh_nxt    = sh_r;
      wd_nxt    = wd_r;
      case (state_r)
         adcdc_pkg::HS_IDLE: begin
            rdy_nxt = 1'h1;
            if (start) begin
               // Start goes low; sclk carries the busy strap.
               bsel_nxt  = busy_sel;
               cs_nxt    = 1'h0;
               sclk_nxt  = busy_sel;
               tmr_nxt   = '0;
               rdy_nxt   = 1'h0;
               state_nxt = adcdc_pkg::HS_LOW;
            end
         end
         adcdc_pkg::HS_LOW: begin
            // Long enough for the low level to ripple down the chain.
            if (tmr_r == `ADCDC_TMR_W'(`ADCDC_CS_LOW_CYC - 1)) begin
               cs_nxt    = 1'h1;
               tmr_nxt   = '0;
               state_nxt = adcdc_pkg::HS_RISE;
            end
         end
         adcdc_pkg::HS_RISE: begin
            // Hold the strap on sclk past the rise, then park it low.
            if (tmr_r == `ADCDC_TMR_W'(`ADCDC_HOLD_CYC - 1)) begin
               sclk_nxt  = 1'h0;
               tmr_nxt   = '0;
               state_nxt = adcdc_pkg::HS_WAIT;
            end
         end
         adcdc_pkg::HS_WAIT: begin
            // Busy mode waits for the chain; otherwise a fixed time.
            if ((bsel_r && sdo_s_r) ||
                (!bsel_r && tmr_r == `ADCDC_TMR_W'(`ADCDC_CONV_CYC - 1))) begin
               sclk_nxt  = 1'h1;
               tmr_nxt   = '0;
               edge_nxt  = '0;
               bit_nxt   = 4'h0;
               state_nxt = adcdc_pkg::HS_HI;
            end
         end
         adcdc_pkg::HS_HI: begin
            // Capture just before the fall; the first busy fall carries no data.
            if (tmr_r == `ADCDC_TMR_W'(SCLK_HALF - 1)) begin
               if (edge_r != '0 || !bsel_r) begin
                  sh_nxt  = {sh_r[`ADCDC_MSB-1:0], sdo_s_r};
                  bit_nxt = bit_r + 4'h1;
                  if (bit_r == 4'hF) begin
                     wd_nxt = {sh_r[`ADCDC_MSB-1:0], sdo_s_r};
                     wv_nxt = 1'h1;
                  end
               end
               sclk_nxt  = 1'h0;
               edge_nxt  = edge_r + EW'(1);
               tmr_nxt   = '0;
               state_nxt = adcdc_pkg::HS_LO;
            end
         end
         adcdc_pkg::HS_LO: begin
            // Sixteen falls per converter, one more in busy mode.
            if (tmr_r == `ADCDC_TMR_W'(SCLK_HALF - 1)) begin
               tmr_nxt = '0;
               if (edge_r == (bsel_r ? EW'(TOT) : EW'(TOT - 1))) begin
                  state_nxt = adcdc_pkg::HS_IDLE;
               end else begin
                  sclk_nxt  = 1'h1;
                  state_nxt = adcdc_pkg::HS_HI;
               end
            end
         end
         default: begin
            state_nxt = adcdc_pkg::HS_IDLE;
         end
      endcase
   end

   // Registers, including the two-stage synchroniser for the data pin.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= adcdc_pkg::HS_IDLE;
         tmr_r   <= '0;
         edge_r  <= '0;
         bit_r   <= 4'h0;
         cs_r    <= 1'h1;
         sclk_r  <= 1'h0;
         bsel_r  <= 1'h0;
         rdy_r   <= 1'h0;
         wv_r    <= 1'h0;
         sh_r    <= '0;
         wd_r    <= '0;
         sdo_m_r <= 1'h1;
         sdo_s_r <= 1'h1;
      end else begin
         state_r <= state_nxt;
         tmr_r   <= tmr_nxt;
         edge_r  <= edge_nxt;
         bit_r   <= bit_nxt;
         cs_r    <= cs_nxt;
         sclk_r  <= sclk_nxt;
         bsel_r  <= bsel_nxt;
         rdy_r   <= rdy_nxt;
         wv_r    <= wv_nxt;
         sh_r    <= sh_nxt;
         wd_r    <= wd_nxt;
         sdo_m_r <= lnk.sdo_line;
         sdo_s_r <= sdo_m_r;
      end
   end

   // Outputs straight from flip-flops.
   assign lnk.conv_start = cs_r;
   assign lnk.sclk       = sclk_r;
   assign ready          = rdy_r;
   assign word_valid     = wv_r;
   assign word_data      = wd_r;

endmodule // adcdc_host

// File: verification/adcdc_link_checker.sv
// Checker for the converter that faces the host, on the link clock.
// Assumes plain copies of the link signals; the pins are async to link_clk.
`timescale 1ns/1ps

module adcdc_link_checker #(
   parameter int CONV_CYC = 40 // Conversion length in link cycles.
) (
   input wire logic link_clk,   // Link clock.
   input wire logic rst_n,      // Reset, active low.
   input wire logic conv_start, // Start line.
   input wire logic sclk,       // Serial clock.
   input wire logic sdi,        // Upstream data.
   input wire logic sdo_o,      // Output value.
   input wire logic sdo_oe,     // Output enable.
   input wire logic sdo_line    // Resolved output wire.
);
   logic       cs_q, sclk_q, sdi_q; // Pin levels one cycle back.
   logic [3:0] sdi_hist;            // Recent upstream levels.
   logic [9:0] since_r, since_nxt;  // Cycles since the last start rise.
   logic [3:0] sfall_r, sfall_nxt;  // Cycles since the last clock fall.
   logic       chain_r, chain_nxt;  // Chain mode taken at the last rise.
   logic       busy_r, busy_nxt;    // Busy variant taken at the last rise.
   logic       fell_r, fell_nxt;    // A clock fall seen in this readout.
   logic       rise, fall;          // Edges seen in this cycle.

   // Edges are judged from last cycle's levels; counters saturate.
   always_comb begin
      rise      = conv_start & ~cs_q;
      fall      = ~sclk & sclk_q;
      since_nxt = rise ? 10'h000 : since_r + {9'h000, ~&since_r};
      sfall_nxt = fall ? 4'h0 : sfall_r + {3'h0, ~&sfall_r};
      chain_nxt = rise ? ~sdi_q : chain_r;
      busy_nxt  = rise ? sclk : busy_r;
      // Falls before the result is due are the host parking its strap.
      fell_nxt  = (rise | (~conv_start & cs_q)) ? 1'b0 :
                  (fell_r | (fall & (since_r >= CONV_CYC)));
   end

   // Registers only; reset levels match the host's idle pins.
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         {cs_q, sclk_q, sdi_q} <= 3'h5;
         {sdi_hist, since_r, sfall_r} <= 18'h0_0000;
         {chain_r, busy_r, fell_r} <= 3'h0;
      end else begin
         {cs_q, sclk_q, sdi_q} <= {conv_start, sclk, sdi};
         sdi_hist <= {sdi_hist[2:0], sdi};
         {since_r, sfall_r} <= {since_nxt, sfall_nxt};
         {chain_r, busy_r, fell_r} <= {chain_nxt, busy_nxt, fell_nxt};
      end
   end

   default clocking cb @(posedge link_clk); endclocking
   default disable iff (!rst_n);

   property p_release;
      !chain_r && since_r == 10'h008 |-> !sdo_oe;
   endproperty
   a_release: assert property (p_release) else $error("output driven outside chain");
   property p_conv_low;
      chain_r && since_r inside {[6:CONV_CYC-1]} |-> !sdo_line;
   endproperty
   a_conv_low: assert property (p_conv_low) else $error("output high in conversion");
   property p_chain_drive;
      chain_r && since_r > 10'h005 |-> sdo_oe;
   endproperty
   a_chain_drive: assert property (p_chain_drive) else $error("chain output released");
   property p_low_pass;
      (!sdi && !conv_start)[*6] |-> sdo_oe && !sdo_o;
   endproperty
   a_low_pass: assert property (p_low_pass) else $error("low not passed on");
   property p_busy_show;
      chain_r && busy_r && !fell_r && sdi && since_r == CONV_CYC + 9 |-> sdo_line;
   endproperty
   a_busy_show: assert property (p_busy_show) else $error("busy not shown");
   property p_busy_own;
      chain_r && busy_r && !fell_r && sdo_line |-> since_r >= CONV_CYC;
   endproperty
   a_busy_own: assert property (p_busy_own) else $error("busy before own result");
   property p_busy_up;
      chain_r && busy_r && !fell_r && $rose(sdo_line) |-> |{sdi_hist, sdi};
   endproperty
   a_busy_up: assert property (p_busy_up) else $error("busy without upstream");
   property p_shift_edge;
      chain_r && fell_r && conv_start && $changed(sdo_line) |-> sfall_r < 4'h6;
   endproperty
   a_shift_edge: assert property (p_shift_edge) else $error("output moved off a fall");
endmodule // adcdc_link_checker

// File: verification/adc_daisy_chain_busy_readout_tb.sv
// Bench: one host reads a chain of two converters and checks each word.
// Assumes the package, map, link interface and design files compile first.
`timescale 1ns/1ps
`include "adcdc_map.svh"

module adc_daisy_chain_busy_readout_tb;
   localparam int CONV = 40;            // Conversion length of both converters.
   logic             sys_clk  = 1'b0;   // System clock, 20 ns.
   logic             link_clk = 1'b0;   // Link clock, 64 ns.
   logic             rst_n    = 1'b0;   // Reset, active low.
   logic             start    = 1'b0;   // Frame request.
   logic             busy_sel = 1'b0;   // Busy variant request.
   logic             tie_r    = 1'b1;   // First input tied to the start line.
   logic             sdi0_r   = 1'b0;   // First input level when not tied.
   logic [`ADCDC_MSB:0] s_up  = 16'h0000; // Upstream converter result.
   logic [`ADCDC_MSB:0] s_last = 16'h0000; // Last converter result.
   logic [15:0]      rnd      = 16'h0033; // Random state.
   logic             ready, word_valid;  // Host status and word strobe.
   logic [`ADCDC_MSB:0] word_data;      // Word from the host.
   logic             chain_mode, busy_mode; // Last converter's mode flags.
   logic [15:0]      exp_q[$];          // Expected words, oldest first.
   int               err_count = 0;     // Mismatches.
   int               checks    = 0;     // Comparisons.
   int               cycles    = 0;     // Run length in system cycles.

   adcdc_link_if l_up();   // Link of the first converter.
   adcdc_link_if l_last(); // Link of the converter the host reads.

   // The start line and clock fan out to both converters; data walks down.
   assign l_up.conv_start = l_last.conv_start;
   assign l_up.sclk       = l_last.sclk;
   assign l_up.sdi        = tie_r ? l_last.conv_start : sdi0_r;
   assign l_last.sdi      = l_up.sdo_line;

   always #10 sys_clk = ~sys_clk;
   always #32 link_clk = ~link_clk;

   adcdc_dev #(.CONV_CYC(CONV)) i_adcdc_dev_up (.link_clk(link_clk), .rst_n(rst_n),
      .lnk(l_up.dev), .sample_data(s_up), .chain_mode(), .busy_mode(), .converting(),
      .result_rdy());
   adcdc_dev #(.CONV_CYC(CONV)) i_adcdc_dev (.link_clk(link_clk), .rst_n(rst_n),
      .lnk(l_last.dev), .sample_data(s_last), .chain_mode(chain_mode),
      .busy_mode(busy_mode), .converting(), .result_rdy());
   adcdc_host #(.N_DEV(2), .SCLK_HALF(16)) i_adcdc_host (.sys_clk(sys_clk), .rst_n(rst_n),
      .lnk(l_last.host), .start(start), .busy_sel(busy_sel), .ready(ready),
      .word_valid(word_valid), .word_data(word_data));
   adcdc_link_checker #(.CONV_CYC(CONV)) i_adcdc_link_checker (.link_clk(link_clk),
      .rst_n(rst_n), .conv_start(l_last.conv_start), .sclk(l_last.sclk), .sdi(l_last.sdi),
      .sdo_o(l_last.sdo_o), .sdo_oe(l_last.sdo_oe), .sdo_line(l_last.sdo_line));

   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   task automatic cmp(input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: expected %h got %h", $time, exp, got);
      end
   endtask

   task automatic end_sim;
      $display("errors %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Bounded wait for the host to go idle; the global timeout catches a hang.
   task automatic wait_ready;
      int n;
      n = 0;
      while (ready !== 1'b1 && n < 5000) begin
         @(posedge sys_clk);
         #2;
         n++;
      end
   endtask

   // One frame. Mode 0 ties the first input to the start line, 1 holds it
   // low, 2 holds it high so nobody chains and the pull-up is read back.
   // Busy needs mode 0 or 2: a head held low never sees a busy enable.
   task automatic frame(input logic bsel, input int mode, input logic poke);
      wait_ready();
      rnd = lfsr(rnd);
      s_last = rnd;
      rnd = lfsr(rnd);
      s_up = rnd;
      tie_r = (mode == 0);
      sdi0_r = (mode == 2);
      busy_sel = bsel;
      exp_q.push_back(mode == 2 ? 16'hffff : s_last);
      exp_q.push_back(mode == 2 ? 16'hffff : s_up);
      start = 1'b1;
      @(posedge sys_clk);
      #2 start = 1'b0;
      // A request while busy must be ignored and add no words.
      if (poke) begin
         repeat (100) @(posedge sys_clk);
         #2 start = 1'b1;
         @(posedge sys_clk);
         #2 start = 1'b0;
      end
      wait_ready();
      cmp({15'h0000, mode != 2}, {15'h0000, chain_mode});
      cmp({15'h0000, bsel}, {15'h0000, busy_mode});
   endtask

   // Each word is matched with the oldest note; an extra word is a mismatch.
   // Sampled mid-cycle, away from the edge that launches the strobe.
   always @(negedge sys_clk) begin
      if (word_valid === 1'b1)
         cmp(exp_q.size() > 0 ? exp_q.pop_front() : ~word_data, word_data);
   end

   // Run limit, about three times the longest expected run.
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 30000) begin
         err_count++;
         end_sim();
      end
   end

   // Non-chain first, while both outputs are still released after reset.
   initial begin
      repeat (8) @(posedge sys_clk);
      #2 rst_n = 1'b1;
      frame(1'b1, 2, 1'b0);
      frame(1'b1, 0, 1'b1);
      frame(1'b0, 1, 1'b0);
      frame(1'b0, 0, 1'b0);
      for (int i = 0; i < 5; i++) begin
         frame(rnd[1] & ~rnd[0], int'(rnd[0]), 1'b0);
      end
      repeat (20) @(posedge sys_clk);
      cmp(16'h0000, 16'(exp_q.size()));
      end_sim();
   end
endmodule // adc_daisy_chain_busy_readout_tb
